// file: design/static_mem_ctrl_pkg.sv
// Purpose: Constants, types and field helpers of the static memory timing engine
// Assumes: 32-bit register words, eight chip selects, 26-bit external address
// Notes: Every field position, offset and reset value lives here
package static_mem_ctrl_pkg;

  // ----
  // Sizes
  // ----
  localparam int CS_COUNT = 8; // Chip selects served
  localparam int CS_W = 3; // Chip select index width
  localparam int ADDR_W = 26; // External address width
  localparam int REG_AW = 8; // Register port address width
  localparam int LEN_W = 11; // Widest length count
  localparam int FLOAT_W = 5; // Float counter width

  typedef logic [LEN_W-1:0] len_t; // Cycle counts

  // ----
  // Register map
  // ----
  localparam logic [3:0] OFS_SETUP = 4'h0; // Setup lengths
  localparam logic [3:0] OFS_PULSE = 4'h4; // Strobe pulse lengths
  localparam logic [3:0] OFS_CYCLE = 4'h8; // Cycle lengths
  localparam logic [3:0] OFS_MODE = 4'hC; // Chip select mode
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h80; // Engine status, end of config space
  localparam int CS_SEL_LO = 4; // Chip select index in address
  localparam logic [31:0] RST_SETUP = 32'h00000000;
  localparam logic [31:0] RST_PULSE = 32'h01010101;
  localparam logic [31:0] RST_CYCLE = 32'h00010001;
  localparam logic [31:0] RST_MODE = 32'h10001000;
  localparam logic [31:0] MASK_SETUP = 32'h3F3F3F3F; // Writable bits
  localparam logic [31:0] MASK_PULSE = 32'h7F7F7F7F;
  localparam logic [31:0] MASK_CYCLE = 32'h01FF01FF;
  localparam logic [31:0] MASK_MODE = 32'h311F3133;

  // ----
  // Field positions
  // ----
  localparam int FLD_WR_STROBE = 0; // In setup and pulse words
  localparam int FLD_WR_CS = 8;
  localparam int FLD_RD_STROBE = 16;
  localparam int FLD_RD_CS = 24;
  localparam int FLD_WR_CYC = 0; // In cycle word
  localparam int FLD_RD_CYC = 16;
  localparam int MODE_RD_CTL = 0; // Mode word bits
  localparam int MODE_WR_CTL = 1;
  localparam int MODE_WAIT = 4;
  localparam int MODE_BAT = 8;
  localparam int MODE_DBW = 12;
  localparam int MODE_TDF = 16;
  localparam int MODE_TDF_OPT = 20;
  localparam int MODE_PAGE_ENABLE = 24;
  localparam int MODE_PS = 28;
  localparam int STAT_BUSY = 0; // Status word bits
  localparam int STAT_FLOAT = 1;
  localparam int STAT_PAGE = 2;
  localparam int STAT_WAIT = 3;
  localparam int PAGE_SHIFT_MIN = 2; // Smallest page is four bytes

  localparam len_t SETUP_HI_MUL = 11'h080; // Weight of setup top bit
  localparam len_t PULSE_HI_MUL = 11'h100; // Weight of pulse top bit
  localparam len_t CYCLE_HI_MUL = 11'h100; // Weight of cycle top bits

  // ----
  // Enumerations
  // ----
  typedef enum logic [1:0] {
    WAIT_OFF = 2'h0,
    WAIT_RSVD = 2'h1,
    WAIT_FROZEN = 2'h2,
    WAIT_READY = 2'h3
  } wait_behaviour_e;

  typedef enum logic [1:0] {
    DBW_8 = 2'h0,
    DBW_16 = 2'h1,
    DBW_32 = 2'h2,
    DBW_RSVD = 2'h3
  } bus_width_sel_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACCESS = 3'h2,
    ST_DONE = 3'h4
  } engine_state_e;

  // ----
  // Carriers
  // ----
  typedef struct packed {
    logic [31:0] setup;
    logic [31:0] pulse;
    logic [31:0] cycle;
    logic [31:0] mode;
  } cs_cfg_s;

  typedef struct packed {
    logic write; // 1 write, 0 read
    logic [CS_W-1:0] cs; // Target chip select
    logic [ADDR_W-1:0] addr; // Byte address
    logic [3:0] be; // Byte lanes wanted
  } mem_req_s;

  typedef struct packed {
    engine_state_e state;
    len_t cnt;
    mem_req_s cur;
    logic cur_page;
    logic page_hit;
    logic page_open;
    logic [CS_W-1:0] page_cs;
    logic [ADDR_W-1:0] page_addr;
    logic [FLOAT_W-1:0] float_cnt;
    logic [CS_W-1:0] float_cs;
    logic float_opt;
    logic ctl_lo;
    logic w1;
    logic w2;
    logic w3;
    logic wait_f;
    logic [CS_COUNT-1:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] bwr_n;
    logic [3:0] bsel_n;
    logic done;
    logic busy;
    logic [31:0] rdata;
    cs_cfg_s [CS_COUNT-1:0] staged;
    cs_cfg_s [CS_COUNT-1:0] active;
  } ctrl_state_s;

  // ----
  // Length decoders
  // ----
  function automatic len_t setup_len(input logic [5:0] f);
    return f[5] ? len_t'(SETUP_HI_MUL + len_t'(f[4:0])) : len_t'(f[4:0]);
  endfunction

  function automatic len_t pulse_len(input logic [6:0] f);
    return f[6] ? len_t'(PULSE_HI_MUL + len_t'(f[5:0])) : len_t'(f[5:0]);
  endfunction

  function automatic len_t cycle_len(input logic [8:0] f);
    return len_t'(len_t'(f[8:7]) * CYCLE_HI_MUL + len_t'(f[6:0]));
  endfunction

endpackage

// file: design/static_mem_timing_ctrl.sv
// Purpose: Timing and mode engine driving external static memory strobes
// Assumes: One access at a time; request held until the done pulse
// Notes: Registers are staged and applied per chip select on a mode write
//
// Contract
// R1 - Write strobe pulse from its pulse field
// R2 - Write chip select pulse from its field
// R3 - Standard read strobe pulse from its field
// R4 - Page reads: later accesses use strobe pulse
// R5 - Standard read chip select pulse from field
// R6 - Page reads: first access uses cs pulse
// R7 - Write cycle total from write cycle field
// R8 - Read cycle total from read cycle field
// R9 - Read control bit picks read controlling signal
// R10 - Write control bit picks write controlling signal
// R11 - Wait sampled only in controlling pulse
// R12 - Wait mode: off, reserved, frozen, ready
// R13 - Frozen: wait suspends then resumes cycle
// R14 - Ready: wait low at pulse end extends
// R15 - Byte write type uses per-byte write strobes
// R16 - Byte select type uses byte select lanes
// R17 - Bus width field; byte type wide only
// R18 - Float cycles plus one block other selects
// R19 - Float optimize overlaps next access setup
// R20 - Page enable selects page burst reads
// R21 - Page size field sets page length
// R22 - Setup lengths from their setup fields
// R23 - New page or select forces long access
// R24 - Page reads hold strobe and select low
// R25 - New timing applies on mode write
// R26 - Hold is remainder, values never checked
//
// Chosen here: the address map and strobed register access.
module static_mem_timing_ctrl
  import static_mem_ctrl_pkg::*;
(
  input wire logic MCLK, // System clock
  input wire logic RESET_N, // Asynchronous reset, low active
  input wire logic [REG_AW-1:0] REG_ADDR, // Register byte address
  input wire logic [31:0] REG_WDATA, // Register write data
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  output logic [31:0] REG_RDATA, // Read data, cycle after strobe
  input wire logic REQ_VALID, // Access wanted, held until done
  input wire mem_req_s REQ, // Access description
  output logic DONE, // Access finished pulse
  output logic BUSY, // Engine not idle
  input wire logic EXT_WAIT_N, // External wait, low stalls
  output logic [CS_COUNT-1:0] CHIP_SELECT_N, // Chip selects, low active
  output logic READ_STROBE_N, // Read strobe, low active
  output logic WRITE_STROBE_N, // Write strobe, low active
  output logic [3:0] BYTE_WRITE_STROBE_N, // Per-byte write strobes
  output logic [3:0] BYTE_SELECT_N // Byte select lanes
);

  // ----
  // Reset release
  // ----
  logic [1:0] rst_sync_r; // Release chain
  logic rst_n; // Synchronous copy of reset

  // Release synchronised so all flops leave reset together
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----
  // State
  // ----
  ctrl_state_s s_r; // Whole engine state
  ctrl_state_s s_nxt; // Next state

  // Phase test: low while setup <= cnt < setup + pulse
  function automatic logic in_phase(input len_t cnt, input len_t setup, input len_t pulse);
    return (cnt >= setup) && (len_t'(cnt - setup) < pulse);
  endfunction

  // Page number of an address for a page size code
  function automatic logic [ADDR_W-1:0] page_tag(input logic [ADDR_W-1:0] a, input logic [1:0] ps);
    return a >> (PAGE_SHIFT_MIN + int'(ps));
  endfunction

  // ----
  // Next-state logic
  // ----
  always_comb
  begin
    logic [CS_W-1:0] reg_cs;
    logic [3:0] reg_sel;
    logic cfg_hit;
    cs_cfg_s rq;
    cs_cfg_s c;
    len_t rq_setup;
    len_t ctl_set;
    len_t ctl_pul;
    len_t total;
    logic allow;
    logic in_pulse;
    logic last_pulse;
    logic hold;
    wait_behaviour_e wm;
    bus_width_sel_e bus_width_sel;
    logic wide;
    logic byte_access_type;
    logic [3:0] lanes;
    logic cs_lo;
    logic rd_lo;
    logic wr_lo;
    logic ctl_now;
    s_nxt = s_r;
    reg_cs = REG_ADDR[CS_SEL_LO +: CS_W];
    reg_sel = REG_ADDR[3:0];
    cfg_hit = REG_ADDR < OFS_STATUS;
    rq = s_r.active[REQ.cs];
    c = s_r.active[s_r.cur.cs];
    rq_setup = '0;
    ctl_set = '0;
    ctl_pul = '0;
    total = '0;
    allow = 1'b0;
    in_pulse = 1'b0;
    last_pulse = 1'b0;
    hold = 1'b0;
    wm = WAIT_OFF;
    cs_lo = 1'b0;
    rd_lo = 1'b0;
    wr_lo = 1'b0;
    bus_width_sel = DBW_8;
    wide = 1'b0;
    byte_access_type = 1'b0;
    lanes = 4'h0;
    ctl_now = 1'b0;
    s_nxt.rdata = '0; // Data stands for one cycle only

    // Wait input: three flops, accepted once the last two agree
    s_nxt.w1 = EXT_WAIT_N;
    s_nxt.w2 = s_r.w1;
    s_nxt.w3 = s_r.w2;
    if (s_r.w2 == s_r.w3)
    begin
      s_nxt.wait_f = s_r.w3;
    end

    // Register writes land in the staged copy
    if (REG_WR && cfg_hit)
    begin
      unique case (reg_sel)
        OFS_SETUP: s_nxt.staged[reg_cs].setup = REG_WDATA & MASK_SETUP;
        OFS_PULSE: s_nxt.staged[reg_cs].pulse = REG_WDATA & MASK_PULSE;
        OFS_CYCLE: s_nxt.staged[reg_cs].cycle = REG_WDATA & MASK_CYCLE;
        OFS_MODE:
        begin
          // Mode write commits the whole set of this select
          s_nxt.staged[reg_cs].mode = REG_WDATA & MASK_MODE;
          s_nxt.active[reg_cs] = s_nxt.staged[reg_cs]; // R25
        end
        default: ; // Unaligned: ignored
      endcase
    end

    // Register reads, zero for anything unmapped
    if (REG_RD && cfg_hit)
    begin
      unique case (reg_sel)
        OFS_SETUP: s_nxt.rdata = s_r.staged[reg_cs].setup;
        OFS_PULSE: s_nxt.rdata = s_r.staged[reg_cs].pulse;
        OFS_CYCLE: s_nxt.rdata = s_r.staged[reg_cs].cycle;
        OFS_MODE: s_nxt.rdata = s_r.staged[reg_cs].mode;
        default: s_nxt.rdata = '0;
      endcase
    end
    else if (REG_RD && REG_ADDR == OFS_STATUS)
    begin
      s_nxt.rdata[STAT_BUSY] = s_r.busy;
      s_nxt.rdata[STAT_FLOAT] = s_r.float_cnt != '0;
      s_nxt.rdata[STAT_PAGE] = s_r.page_open;
      s_nxt.rdata[STAT_WAIT] = s_r.wait_f;
    end

    // Float period runs down every cycle
    if (s_r.float_cnt != '0)
    begin
      s_nxt.float_cnt = FLOAT_W'(s_r.float_cnt - 1'b1);
    end

    // Setup of the next request's controlling signal
    if (REQ.write)
    begin
      rq_setup = rq.mode[MODE_WR_CTL] ? setup_len(rq.setup[FLD_WR_STROBE +: 6])
                                      : setup_len(rq.setup[FLD_WR_CS +: 6]); // R10 R22
    end
    else
    begin
      rq_setup = rq.mode[MODE_RD_CTL] ? setup_len(rq.setup[FLD_RD_STROBE +: 6])
                                      : setup_len(rq.setup[FLD_RD_CS +: 6]); // R9 R22
    end

    // Another select waits out the float, or overlaps it with setup
    allow = (s_r.float_cnt == '0) || (s_r.float_cs == REQ.cs) // R18
         || (s_r.float_opt && len_t'(s_r.float_cnt) <= rq_setup); // R19

    // Controlling signal of the running access
    if (s_r.cur.write)
    begin
      ctl_set = c.mode[MODE_WR_CTL] ? setup_len(c.setup[FLD_WR_STROBE +: 6])
                                    : setup_len(c.setup[FLD_WR_CS +: 6]); // R10
      ctl_pul = c.mode[MODE_WR_CTL] ? pulse_len(c.pulse[FLD_WR_STROBE +: 7])
                                    : pulse_len(c.pulse[FLD_WR_CS +: 7]);
      total = cycle_len(c.cycle[FLD_WR_CYC +: 9]); // R7
    end
    else
    begin
      ctl_set = c.mode[MODE_RD_CTL] ? setup_len(c.setup[FLD_RD_STROBE +: 6])
                                    : setup_len(c.setup[FLD_RD_CS +: 6]); // R9
      ctl_pul = c.mode[MODE_RD_CTL] ? pulse_len(c.pulse[FLD_RD_STROBE +: 7])
                                    : pulse_len(c.pulse[FLD_RD_CS +: 7]);
      total = cycle_len(c.cycle[FLD_RD_CYC +: 9]); // R8
    end

    // Page reads: length is the access time alone
    if (s_r.cur_page)
    begin
      total = s_r.page_hit ? pulse_len(c.pulse[FLD_RD_STROBE +: 7]) // R4
                           : pulse_len(c.pulse[FLD_RD_CS +: 7]); // R6 R23
    end

    // Wait is looked at only inside the controlling pulse
    in_pulse = in_phase(s_r.cnt, ctl_set, ctl_pul); // R11
    last_pulse = len_t'(s_r.cnt + 1'b1) == len_t'(ctl_set + ctl_pul);
    wm = wait_behaviour_e'(c.mode[MODE_WAIT +: 2]);
    // Page mode and wait do not mix; wait is ignored there
    hold = !s_r.cur_page && !s_r.wait_f
        && ((wm == WAIT_FROZEN && in_pulse) // R12 R13
         || (wm == WAIT_READY && last_pulse)); // R12 R14

    // ----
    // Sequencer
    // ----
    unique case (s_r.state)
      ST_IDLE:
      begin
        if (REQ_VALID && allow)
        begin
          // Latch the access and judge the page
          s_nxt.state = ST_ACCESS;
          s_nxt.cnt = '0;
          s_nxt.cur = REQ;
          s_nxt.cur_page = !REQ.write && rq.mode[MODE_PAGE_ENABLE]; // R20
          s_nxt.page_hit = s_nxt.cur_page && s_r.page_open
                        && s_r.page_cs == REQ.cs
                        && page_tag(REQ.addr, rq.mode[MODE_PS +: 2]) == s_r.page_addr; // R21 R23
          s_nxt.page_open = s_nxt.cur_page; // Any other access breaks the page
          s_nxt.page_cs = REQ.cs;
          s_nxt.page_addr = page_tag(REQ.addr, rq.mode[MODE_PS +: 2]); // R21
        end
      end
      ST_ACCESS:
      begin
        // Frozen or extended: counter stops where it is
        if (!hold)
        begin
          if (len_t'(s_r.cnt + 1'b1) >= total) // R7 R8 R26
          begin
            s_nxt.state = ST_DONE;
          end
          else
          begin
            s_nxt.cnt = len_t'(s_r.cnt + 1'b1);
          end
        end
      end
      ST_DONE:
      begin
        // One dead cycle lets the master drop its request
        s_nxt.state = ST_IDLE;
      end
      default:
      begin
        s_nxt.state = ST_IDLE; // Illegal code recovers
      end
    endcase

    // ----
    // Strobe generation from the next state
    // ----
    c = s_nxt.active[s_nxt.cur.cs];
    if (s_nxt.state == ST_ACCESS)
    begin
      if (s_nxt.cur_page)
      begin
        cs_lo = 1'b1; // R24
        rd_lo = 1'b1; // R24
      end
      else if (s_nxt.cur.write)
      begin
        cs_lo = in_phase(s_nxt.cnt, setup_len(c.setup[FLD_WR_CS +: 6]),
                         pulse_len(c.pulse[FLD_WR_CS +: 7])); // R2 R22
        wr_lo = in_phase(s_nxt.cnt, setup_len(c.setup[FLD_WR_STROBE +: 6]),
                         pulse_len(c.pulse[FLD_WR_STROBE +: 7])); // R1 R22
      end
      else
      begin
        cs_lo = in_phase(s_nxt.cnt, setup_len(c.setup[FLD_RD_CS +: 6]),
                         pulse_len(c.pulse[FLD_RD_CS +: 7])); // R5 R22
        rd_lo = in_phase(s_nxt.cnt, setup_len(c.setup[FLD_RD_STROBE +: 6]),
                         pulse_len(c.pulse[FLD_RD_STROBE +: 7])); // R3 R22
      end
    end

    // Lane use depends on width and byte access type
    bus_width_sel = bus_width_sel_e'(c.mode[MODE_DBW +: 2]);
    wide = (bus_width_sel == DBW_16) || (bus_width_sel == DBW_32); // R17
    byte_access_type = c.mode[MODE_BAT] && wide; // R17
    unique case (bus_width_sel)
      DBW_16: lanes = 4'h3;
      DBW_32: lanes = 4'hF;
      default: lanes = 4'h0; // Narrow or reserved: no lanes
    endcase
    lanes = lanes & s_nxt.cur.be;

    s_nxt.cs_n = '1;
    if (cs_lo)
    begin
      s_nxt.cs_n[s_nxt.cur.cs] = 1'b0;
    end
    s_nxt.rd_n = !rd_lo;
    s_nxt.wr_n = !(wr_lo && !byte_access_type); // R16
    s_nxt.bwr_n = ~((wr_lo && byte_access_type) ? lanes : 4'h0); // R15
    s_nxt.bsel_n = ~((cs_lo && wide && !byte_access_type) ? lanes : 4'h0); // R16

    // Rising edge of read control starts the float period
    ctl_now = s_nxt.cur.write ? (c.mode[MODE_WR_CTL] ? wr_lo : cs_lo)
                              : (c.mode[MODE_RD_CTL] ? rd_lo : cs_lo);
    s_nxt.ctl_lo = ctl_now;
    if (!s_r.cur.write && s_r.ctl_lo && !ctl_now)
    begin
      c = s_r.active[s_r.cur.cs];
      s_nxt.float_cnt = FLOAT_W'(c.mode[MODE_TDF +: 4]) + 1'b1; // R18
      s_nxt.float_cs = s_r.cur.cs;
      s_nxt.float_opt = c.mode[MODE_TDF_OPT]; // R19
    end

    s_nxt.done = s_nxt.state == ST_DONE;
    s_nxt.busy = s_nxt.state != ST_IDLE;
  end

  // ----
  // State register
  // ----
  // Reset loads documented register values and idle strobes
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.w1 <= 1'b1;
      s_r.w2 <= 1'b1;
      s_r.w3 <= 1'b1;
      s_r.wait_f <= 1'b1;
      s_r.cs_n <= '1;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
      s_r.bwr_n <= 4'hF;
      s_r.bsel_n <= 4'hF;
      for (int i = 0; i < CS_COUNT; i++)
      begin
        s_r.staged[i] <= '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
        s_r.active[i] <= '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
      end
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----
  // Outputs, all straight from flops
  // ----
  assign REG_RDATA = s_r.rdata;
  assign DONE = s_r.done;
  assign BUSY = s_r.busy;
  assign CHIP_SELECT_N = s_r.cs_n;
  assign READ_STROBE_N = s_r.rd_n;
  assign WRITE_STROBE_N = s_r.wr_n;
  assign BYTE_WRITE_STROBE_N = s_r.bwr_n;
  assign BYTE_SELECT_N = s_r.bsel_n;

endmodule // static_mem_timing_ctrl

// file: testbench/ext_static_dev.sv
// Purpose: External static device model driving the wait line
// Assumes: Strobes low active; wait line has a pull-up
// Notes: Stall length set by the bench; zero answers at once
module ext_static_dev (
  input wire logic MCLK, // System clock
  input wire logic rd_n, // Read strobe on the bus
  input wire logic wr_n, // Any write strobe on the bus
  input wire logic [31:0] stall, // Wait cycles per access
  output logic wait_n // Wait line, low stalls
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle_r; // Both strobes high last edge
  int left_r; // Wait cycles still owed
  // Stall starts as a strobe falls, inside its pulse
  always @(posedge MCLK)
  begin
    idle_r <= rd_n & wr_n;
    if (idle_r && !(rd_n & wr_n))
      left_r <= stall;
    else if (left_r > 0)
      left_r <= left_r - 1;
  end
  // Released line rises through its pull-up
  assign wait_n = (left_r == 0);
endmodule // ext_static_dev

// file: testbench/static_mem_asserts.sv
// Purpose: Port-level checks of the static memory timing engine
// Assumes: One clock MCLK, reset RESET_N low active
// Notes: Bound to the top module; sees its ports only
module static_mem_asserts
  import static_mem_ctrl_pkg::*;
(
  input wire logic MCLK, // System clock
  input wire logic RESET_N, // Reset, low active
  input wire logic [REG_AW-1:0] REG_ADDR, // Register address
  input wire logic [31:0] REG_WDATA, // Register write data
  input wire logic REG_WR, // Register write strobe
  input wire logic REG_RD, // Register read strobe
  input wire logic [31:0] REG_RDATA, // Register read data
  input wire logic DONE, // Access finished
  input wire logic BUSY, // Engine busy
  input wire logic [CS_COUNT-1:0] CHIP_SELECT_N, // Chip selects
  input wire logic READ_STROBE_N, // Read strobe
  input wire logic WRITE_STROBE_N, // Write strobe
  input wire logic [3:0] BYTE_WRITE_STROBE_N // Per-byte write strobes
);
  // ----
  // Clocking
  // ----
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // Write then read of one word echoes its writable bits
  property reg_echo(logic [3:0] ofs, logic [31:0] msk);
    REG_WR && REG_ADDR[3:0] == ofs && !REG_ADDR[7] ##1 REG_RD && REG_ADDR == $past(REG_ADDR)
      |=> REG_RDATA == ($past(REG_WDATA, 2) & msk);
  endproperty

  // ----
  // Checks
  // ----
  a_setup_echo: assert property (reg_echo(OFS_SETUP, MASK_SETUP))
    else $error("setup readback");
  a_pulse_echo: assert property (reg_echo(OFS_PULSE, MASK_PULSE))
    else $error("pulse readback");
  a_cycle_echo: assert property (reg_echo(OFS_CYCLE, MASK_CYCLE))
    else $error("cycle readback");
  a_mode_echo: assert property (reg_echo(OFS_MODE, MASK_MODE))
    else $error("mode readback");
  a_done_single_pulse: assert property (DONE |=> !DONE)
    else $error("done too long");
  a_done_in_busy: assert property (DONE |-> BUSY)
    else $error("done outside busy");
  a_busy_ends_done: assert property ($fell(BUSY) |-> $past(DONE))
    else $error("busy fell, no done");
  a_one_select: assert property ($onehot0(~CHIP_SELECT_N))
    else $error("two selects low");
  a_byte_write_excl: assert property (!(&BYTE_WRITE_STROBE_N) |-> WRITE_STROBE_N)
    else $error("write strobes clash");
  a_idle_no_write: assert property (!BUSY |-> WRITE_STROBE_N && &BYTE_WRITE_STROBE_N)
    else $error("write while idle");
  a_read_fall_busy: assert property ($fell(READ_STROBE_N) |-> BUSY)
    else $error("read while idle");

  // Main scenarios reached
  c_done: cover property (DONE);
  c_read: cover property ($fell(READ_STROBE_N));
  c_byte_write: cover property (!(&BYTE_WRITE_STROBE_N));
endmodule // static_mem_asserts

bind static_mem_timing_ctrl static_mem_asserts chk (
  .MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DONE(DONE), .BUSY(BUSY),
  .CHIP_SELECT_N(CHIP_SELECT_N), .READ_STROBE_N(READ_STROBE_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .BYTE_WRITE_STROBE_N(BYTE_WRITE_STROBE_N)
);

// file: testbench/tb_top.sv
// Purpose: Self-checking bench of the static memory timing engine
// Assumes: Register port and request handshake as handed over
// Notes: Lengths counted on falling edges, where outputs are settled
module tb_top
  import static_mem_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, reg_wr, reg_rd, req_valid, done, busy, wait_n, rd_n, wr_n;
  logic [7:0] reg_addr, cs_n;
  logic [31:0] wdat, rdat, r;
  logic [3:0] bw_n, bs_n, bw, bs;
  mem_req_s req;
  int err_total, tests_run, lat, gap, fst, cs_lo, rd_lo, wr_lo, stall, cyc;
  logic [31:0] rstv [4] = '{RST_SETUP, RST_PULSE, RST_CYCLE, RST_MODE};
  logic [31:0] mskv [4] = '{MASK_SETUP, MASK_PULSE, MASK_CYCLE, MASK_MODE};
  int pa [3] = '{256, 261, 264}; // Page probes: new, same, next page
  int pe [3] = '{6, 3, 6}; // Long, short, long access
  int wm [3] = '{0, 2, 3}; // Wait off, frozen, ready

  static_mem_timing_ctrl DUT (.MCLK(mclk), .RESET_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(wdat), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdat),
    .REQ_VALID(req_valid), .REQ(req), .DONE(done), .BUSY(busy), .EXT_WAIT_N(wait_n),
    .CHIP_SELECT_N(cs_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .BYTE_WRITE_STROBE_N(bw_n), .BYTE_SELECT_N(bs_n));
  ext_static_dev dev (.MCLK(mclk), .rd_n(rd_n), .wr_n(wr_n & (&bw_n)), .stall(stall),
    .wait_n(wait_n));

  // ----
  // Clock, hang guard, verdict
  // ----
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Run needs far fewer cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("counts: %0d checks, %0d mismatches", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task cnt(input int g, input int lo, input int hi, input string m);
    tests_run++;
    if (g < lo || g > hi)
    begin
      err_total++;
      $display("unexpected at %0t: %s count %0d", $time, m, g);
    end
  endtask

  // ----
  // Register port and request handshake
  // ----
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    wdat <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = rdat;
  endtask
  // Write, then read back with no gap
  task echo(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wreg(a, d);
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(rdat, e, "echo");
  endtask
  // Mode written last so the set goes live
  task cfg(input logic [2:0] c, input logic [31:0] s, p, y, m);
    wreg({1'b0, c, OFS_SETUP}, s);
    wreg({1'b0, c, OFS_PULSE}, p);
    wreg({1'b0, c, OFS_CYCLE}, y);
    wreg({1'b0, c, OFS_MODE}, m);
  endtask
  // Request held until done; counts busy, stall and low cycles
  task automatic acc(input logic w, input logic [2:0] c, input int a, input logic [3:0] b);
    lat = -1;
    gap = -1;
    {cs_lo, rd_lo, wr_lo, fst} = '0;
    {bw, bs} = 8'hFF;
    @(posedge mclk);
    req <= '{w, c, 26'(a), b};
    req_valid <= 1'b1;
    do
    begin
      @(negedge mclk);
      if (busy === 1'b1)
        lat++;
      else
        gap++;
      if (cs_n[c] === 1'b0 && cs_lo == 0)
        fst = lat;
      cs_lo += int'(cs_n[c] === 1'b0);
      rd_lo += int'(rd_n === 1'b0);
      wr_lo += int'(wr_n === 1'b0);
      bw &= bw_n;
      bs &= bs_n;
    end
    while (done !== 1'b1);
    @(posedge mclk);
    req_valid <= 1'b0;
  endtask

  // ----
  // Tests
  // ----
  initial
  begin
    {rst_n, reg_wr, reg_rd, req_valid} = '0;
    {reg_addr, wdat, req} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 4; i++)
    begin
      rreg(8'(4 * i), r);
      chk(r, rstv[i], "reset cs0");
      rreg(8'(112 + 4 * i), r);
      chk(r, rstv[i], "reset cs7");
      echo(8'(112 + 4 * i), 32'hFFFFFFFF, mskv[i]);
    end
    rreg(8'h84, r);
    chk(r, 32'h0, "unmapped");
    rreg(8'h80, r);
    chk(r, 32'h8, "status idle");
    $display("test registers finished");
    cfg(3'h0, 32'h00010001, 32'h05030402, 32'h00070006, 32'h00002002);
    acc(1'b1, 3'h0, 16, 4'h5);
    cnt(lat, 6, 6, "write cycle");
    cnt(wr_lo, 2, 2, "write strobe");
    cnt(cs_lo, 4, 4, "write select");
    chk(32'(bs), 32'hA, "byte selects");
    wreg(8'h0C, 32'h00002102);
    acc(1'b1, 3'h0, 16, 4'h6);
    chk(32'(bw), 32'h9, "byte writes");
    cnt(wr_lo, 0, 0, "single strobe");
    wreg(8'h0C, 32'h00000002);
    acc(1'b1, 3'h0, 16, 4'hF);
    chk(32'({bw, bs}), 32'hFF, "narrow lanes");
    acc(1'b0, 3'h0, 32, 4'hF);
    cnt(lat, 7, 7, "read cycle");
    cnt(rd_lo, 3, 3, "read strobe");
    cnt(cs_lo, 5, 5, "read select");
    wreg(8'h04, 32'h42410402);
    wreg(8'h08, 32'h00840006);
    acc(1'b0, 3'h0, 32, 4'hF);
    cnt(rd_lo, 3, 3, "staged only");
    wreg(8'h0C, 32'h00000003);
    acc(1'b0, 3'h0, 32, 4'hF);
    cnt(lat, 260, 260, "long read cycle");
    cnt(rd_lo, 257, 257, "long read strobe");
    cnt(cs_lo, 258, 258, "long read select");
    $display("test timing finished");
    cfg(3'h0, 32'h00000001, 32'h02020402, 32'h00020006, 32'h000F0001);
    acc(1'b0, 3'h0, 0, 4'hF);
    acc(1'b1, 3'h1, 0, 4'h3);
    cnt(gap, 1, 16, "float block");
    acc(1'b0, 3'h0, 0, 4'hF);
    acc(1'b0, 3'h0, 0, 4'hF);
    cnt(gap, 0, 0, "same select");
    cfg(3'h1, 32'h21212121, 32'h02020202, 32'h00830083, 32'h10001000);
    wreg(8'h0C, 32'h001F0001);
    acc(1'b0, 3'h0, 0, 4'hF);
    acc(1'b1, 3'h1, 0, 4'h3);
    cnt(gap, 0, 0, "float overlap");
    cnt(lat, 259, 259, "cycle high bits");
    cnt(fst, 129, 130, "setup high bit");
    $display("test float finished");
    cfg(3'h2, 32'h0, 32'h06030101, 32'h00010001, 32'h11000000);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, 3'h2, pa[i], 4'hF);
      cnt(lat, pe[i], pe[i], "page access");
      cnt(int'(rd_lo == cs_lo && rd_lo > 0), 1, 1, "page strobes");
    end
    stall = 12;
    cfg(3'h4, 32'h0, 32'h08080808, 32'h000C000C, 32'h00000003);
    for (int i = 0; i < 3; i++)
    begin
      wreg(8'h4C, 32'(wm[i] << 4) | 32'h3);
      acc(1'b0, 3'h4, 64, 4'hF);
      cnt(lat, wm[i] > 0 ? 13 : 12, wm[i] > 0 ? 32 : 12, "wait");
    end
    $display("test page and wait finished");
    give_verdict();
  end
endmodule // tb_top
